/* hdl/gpm_pkg.sv */
// constants and types for the multiplexed-pin gpio port
package gpm_pkg;
  // ---------------------------------------------------------------
  // register map (printed offsets are word indices)
  // ---------------------------------------------------------------
  localparam int PIN_N = 8;
  localparam logic [7:0] IDX_PIN_OUTPUT_ENABLE = 8'h44;
  localparam logic [7:0] IDX_PIN_OUTPUT_VALUE = 8'h45;
  localparam logic [7:0] IDX_PIN_INPUT_LEVEL = 8'h46;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [7:0] RST_PIN_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] RST_PIN_OUTPUT_VALUE = 8'h00;
  // ---------------------------------------------------------------
  // pin positions inside every pin register
  // ---------------------------------------------------------------
  localparam int AUX_BIT = 7;
  localparam int CLK_BIT = 6;
  localparam int SEL_B_BIT = 5;
  localparam int SEL_A_BIT = 4;
  localparam int TCK_BIT = 3;
  localparam int TMS_BIT = 2;
  localparam int TDI_BIT = 1;
  localparam int TDO_BIT = 0;
  localparam logic [7:0] SCAN_PIN_MASK = 8'h0f;
  // ---------------------------------------------------------------
  // ahb-lite encodings and bus phase state
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  typedef enum logic [2:0]
  {
    GPM_IDLE = 3'h1,
    GPM_WR = 3'h2,
    GPM_RD = 3'h4
  } gpm_phase_e;
endpackage

/* hdl/gpm_pin_if.sv */
// carrier between the register block and the pin multiplexer
`timescale 1ns/1ps
interface gpm_pin_if;
  logic [7:0] drv_en;
  logic [7:0] drv_val;
  logic [7:0] dflt_out;
  logic [7:0] dflt_oe;
  logic scan_on;
  logic [7:0] level;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  modport ctl
  (
    output drv_en, drv_val, dflt_out, dflt_oe, scan_on,
    input level, pad_out, pad_oe
  );
  modport mux
  (
    input drv_en, drv_val, dflt_out, dflt_oe, scan_on,
    output level, pad_out, pad_oe
  );
endinterface

/* hdl/gpm_pin_mux.sv */
// per-pin output mux, drive enables and input synchroniser
`timescale 1ns/1ps
module gpm_pin_mux
  import gpm_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [7:0] pad_in_i, // raw pin levels
  gpm_pin_if.mux pif // register side
);
  typedef struct packed
  {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] out;
    logic [7:0] oe;
  } gpm_mux_s;

  gpm_mux_s st_ff;
  gpm_mux_s nxt_st;
  logic [7:0] eff_out;
  logic [7:0] eff_oe;

  // ---------------------------------------------------------------
  // per-pin selection between gpio and default function
  // ---------------------------------------------------------------
  for (genvar i = 0; i < PIN_N; i++)
  begin : g_pin
    logic own;
    // scan pins stay with boundary scan while it is active
    assign own = pif.drv_en[i] & ~(pif.scan_on & SCAN_PIN_MASK[i]);
    // gpio drives from the value register, else default job
    assign eff_out[i] = own ? pif.drv_val[i] : pif.dflt_out[i];
    assign eff_oe[i] = own ? 1'b1 : pif.dflt_oe[i];
  end

  // next state: two-stage sync, registered pad drive
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = pad_in_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.out = eff_out;
    nxt_st.oe = eff_oe;
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // outputs straight from flops
  assign pif.level = st_ff.s2;
  assign pif.pad_out = st_ff.out;
  assign pif.pad_oe = st_ff.oe;
endmodule

/* hdl/gpm_gpio_port.sv */
// eight-pin multiplexed gpio port with ahb-lite register access
//
// Notes on behaviour
// - bit 7 of enable makes the aux signal input pin drive as gpio.
// - bit 6 makes the clock output pin gpio, dropping its clock output.
// - bit 5 makes host interface select pin b drive as gpio.
// - bit 4 makes host interface select pin a drive as gpio.
// - bits 3..0 make the scan pins tck, tms, tdi, tdo gpio.
// - with boundary scan active the four scan enable bits do nothing.
// - each value register bit is what its pin's output buffer drives while that pin is gpio-owned.
// - each level register bit shows the pin's current input level.
// - level register ignores writes; bit 6 shows the clock pin level.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module gpm_gpio_port
  import gpm_pkg::*;
(
  input wire logic clk_i, // system clock, 25 mhz
  input wire logic resetn_i, // async reset, active low
  input wire logic hsel_i, // slave select
  input wire logic [31:0] haddr_i, // byte address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // 1 write, 0 read
  input wire logic [2:0] hsize_i, // transfer size
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  output logic [31:0] hrdata_o, // read data
  output logic hreadyout_o, // slave ready
  output logic hresp_o, // response
  input wire logic scan_active_i, // boundary scan on (nonvolatile)
  input wire logic [7:0] dflt_out_i, // default function drive
  input wire logic [7:0] dflt_oe_i, // default function enable
  input wire logic [7:0] pad_in_i, // pin input buffers
  output logic [7:0] pad_out_o, // pin output buffers
  output logic [7:0] pad_oe_o // pin drive enables, high drives
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    gpm_phase_e phase;
    logic [7:0] idx;
    logic [7:0] en;
    logic [7:0] val;
    logic [31:0] rdata;
    logic warm;
  } gpm_port_s;

  localparam gpm_port_s RST_ST = '{
    phase: GPM_IDLE,
    idx: 8'h00,
    en: RST_PIN_OUTPUT_ENABLE,
    val: RST_PIN_OUTPUT_VALUE,
    rdata: 32'h0000_0000,
    warm: 1'b0
  };

  gpm_port_s st_ff;
  gpm_port_s nxt_st;
  logic addr_take;
  logic [7:0] req_idx;

  gpm_pin_if pif();

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  // a transfer is taken when selected, NONSEQ or SEQ (htrans bit 1 set) and bus ready
  assign addr_take = hsel_i & htrans_i[1] & hready_i;
  assign req_idx = haddr_i[IDX_MSB:IDX_LSB];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.warm = 1'b1;
    nxt_st.rdata = 32'h0000_0000;
    // commit a write at the end of its data phase
    if (st_ff.phase == GPM_WR && hready_i)
    begin
      case (st_ff.idx)
        IDX_PIN_OUTPUT_ENABLE: nxt_st.en = hwdata_i[7:0];
        IDX_PIN_OUTPUT_VALUE: nxt_st.val = hwdata_i[7:0];
        default: ; // level register and holes ignore writes
      endcase
    end
    // data phase ends whenever the bus is ready
    if (hready_i)
      nxt_st.phase = GPM_IDLE;
    if (addr_take)
    begin
      nxt_st.idx = req_idx;
      nxt_st.phase = hwrite_i ? GPM_WR : GPM_RD;
      // read data uses next values so a write just before is seen
      if (!hwrite_i)
      begin
        case (req_idx)
          IDX_PIN_OUTPUT_ENABLE: nxt_st.rdata = {24'h00_0000, nxt_st.en};
          IDX_PIN_OUTPUT_VALUE: nxt_st.rdata = {24'h00_0000, nxt_st.val};
          IDX_PIN_INPUT_LEVEL: nxt_st.rdata = {24'h00_0000, pif.level};
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st_ff <= RST_ST;
    else
      st_ff <= nxt_st;
  end

  // ---------------------------------------------------------------
  // pin multiplexer
  // ---------------------------------------------------------------
  // register values and default-function drive into the mux
  assign pif.drv_en = st_ff.en;
  assign pif.drv_val = st_ff.val;
  assign pif.dflt_out = dflt_out_i;
  assign pif.dflt_oe = dflt_oe_i;
  assign pif.scan_on = scan_active_i;

  gpm_pin_mux u_mux
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pad_in_i(pad_in_i),
    .pif(pif)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // zero wait states, always okay; hrdata from its flop
  assign hrdata_o = st_ff.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = HRESP_OKAY;
  assign pad_out_o = pif.pad_out;
  assign pad_oe_o = pif.pad_oe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // address phase of a write to the given register index
  sequence s_wr_addr(logic [7:0] idx);
    hsel_i && htrans_i == HTRANS_NONSEQ && hwrite_i && hready_i && req_idx == idx;
  endsequence

  // address phase of a read from the given register index
  sequence s_rd_addr(logic [7:0] idx);
    hsel_i && htrans_i == HTRANS_NONSEQ && !hwrite_i && hready_i && req_idx == idx;
  endsequence

  // a whole write: address phase, then a ready data phase
  sequence s_wr_done(logic [7:0] idx);
    s_wr_addr(idx) ##1 hready_i;
  endsequence

  // gpio-owned pin drives the registered value one cycle later
  property p_gpio_drive(int b, logic scan_pin);
    st_ff.warm && $past(st_ff.en[b]) && !($past(scan_active_i) && scan_pin)
      |-> pad_oe_o[b] && pad_out_o[b] == $past(st_ff.val[b]);
  endproperty

  a_aux_gpio_drive: assert property (p_gpio_drive(AUX_BIT, 1'b0))
    else $error("aux pin not driven as gpio");

  a_clk_gpio_drive: assert property (p_gpio_drive(CLK_BIT, 1'b0))
    else $error("clock pin not driven as gpio");

  // clock function is gone: pin follows the value bit, not the clock
  a_clk_func_off: assert property (st_ff.warm && $past(st_ff.en[CLK_BIT]) &&
    $past(st_ff.val[CLK_BIT]) != $past(dflt_out_i[CLK_BIT])
    |-> pad_out_o[CLK_BIT] != $past(dflt_out_i[CLK_BIT]))
    else $error("clock output still routed to gpio pin");

  a_selb_gpio_drive: assert property (p_gpio_drive(SEL_B_BIT, 1'b0))
    else $error("select b pin not driven as gpio");

  a_sela_gpio_drive: assert property (p_gpio_drive(SEL_A_BIT, 1'b0))
    else $error("select a pin not driven as gpio");

  a_tck_gpio_drive: assert property (p_gpio_drive(TCK_BIT, 1'b1))
    else $error("tck pin not driven as gpio");

  a_tdo_gpio_drive: assert property (p_gpio_drive(TDO_BIT, 1'b1))
    else $error("tdo pin not driven as gpio");

  // all four scan pins obey their enables when scan is off
  a_scan_gpio_all: assert property (st_ff.warm && !$past(scan_active_i)
    |-> (($past(st_ff.en[3:0]) & ~pad_oe_o[3:0]) == 4'h0))
    else $error("enabled scan pin not driving");

  // scan keeps its pins whatever the enables say
  a_scan_keeps_pins: assert property (st_ff.warm && $past(scan_active_i)
    |-> pad_oe_o[3:0] == $past(dflt_oe_i[3:0]) && pad_out_o[3:0] == $past(dflt_out_i[3:0]))
    else $error("scan pins taken from boundary scan");

  // a completed write lands in the value register
  a_val_write: assert property (s_wr_done(IDX_PIN_OUTPUT_VALUE)
    |=> st_ff.val == $past(hwdata_i[7:0]))
    else $error("value register missed a write");

  // value written shows on every gpio-owned pin two cycles on
  a_val_to_pad: assert property (s_wr_done(IDX_PIN_OUTPUT_VALUE) ##1 !scan_active_i
    |=> ((st_ff.en & (pad_out_o ^ $past(st_ff.val))) == 8'h00))
    else $error("pin output differs from value register");

  // a read of the value register returns it in the data phase
  a_val_read: assert property (s_rd_addr(IDX_PIN_OUTPUT_VALUE)
    |=> hrdata_o == {24'h00_0000, st_ff.val})
    else $error("value register read back wrong");

  // level read returns the synchronised pin levels
  a_level_read: assert property (s_rd_addr(IDX_PIN_INPUT_LEVEL)
    |=> hrdata_o == {24'h00_0000, $past(pif.level)})
    else $error("level register read back wrong");

  // level register follows the pins after two sync stages
  a_level_sync: assert property (st_ff.warm && $past(st_ff.warm)
    |-> pif.level == $past(pad_in_i, 2))
    else $error("pin level not two stages behind pin");

  // clock pin level sits in bit 6 of the level register
  a_clk_level_bit: assert property (s_rd_addr(IDX_PIN_INPUT_LEVEL)
    |=> hrdata_o[CLK_BIT] == $past(pif.level[CLK_BIT]))
    else $error("clock pin level not in bit 6");

  // writes to the level register leave the enable and value registers alone
  a_level_no_write: assert property (s_wr_done(IDX_PIN_INPUT_LEVEL)
    |=> st_ff.en == $past(st_ff.en) && st_ff.val == $past(st_ff.val))
    else $error("level register write changed state");

  // a pin with its enable clear keeps its default drive
  a_idle_pin_dflt: assert property (st_ff.warm
    |-> ((~$past(st_ff.en) & (pad_oe_o ^ $past(dflt_oe_i))) == 8'h00)
    && ((~$past(st_ff.en) & (pad_out_o ^ $past(dflt_out_i))) == 8'h00))
    else $error("disabled pin not on default function");

  // bus answer is always ready and okay
  a_bus_okay: assert property (hreadyout_o && hresp_o == HRESP_OKAY)
    else $error("slave answer not ready okay");

  // ---------------------------------------------------------------
  // register bus, remaining pin drive and clock level checks
  // ---------------------------------------------------------------
  // tms and tdi pins obey their own enables
  a_tms_gpio_drive: assert property (p_gpio_drive(TMS_BIT, 1'b1))
    else $error("tms pin not driven as gpio");

  a_tdi_gpio_drive: assert property (p_gpio_drive(TDI_BIT, 1'b1))
    else $error("tdi pin not driven as gpio");

  // with scan active the four upper pins still obey their enables
  a_scan_upper_free: assert property (st_ff.warm && $past(scan_active_i)
    |-> (($past(st_ff.en[7:4]) & ~pad_oe_o[7:4]) == 4'h0))
    else $error("upper pin lost gpio drive during scan");

  // a completed write lands in the enable register
  a_en_write: assert property (s_wr_done(IDX_PIN_OUTPUT_ENABLE)
    |=> st_ff.en == $past(hwdata_i[7:0]))
    else $error("enable register missed a write");

  // a read of the enable register returns it in the data phase
  a_en_read: assert property (s_rd_addr(IDX_PIN_OUTPUT_ENABLE)
    |=> hrdata_o == {24'h00_0000, st_ff.en})
    else $error("enable register read back wrong");

  // enable register changes only at the end of its own write
  a_en_hold: assert property (!(st_ff.phase == GPM_WR && st_ff.idx == IDX_PIN_OUTPUT_ENABLE
    && hready_i) |=> st_ff.en == $past(st_ff.en))
    else $error("enable register changed without a write");

  // value register changes only at the end of its own write
  a_val_hold: assert property (!(st_ff.phase == GPM_WR && st_ff.idx == IDX_PIN_OUTPUT_VALUE
    && hready_i) |=> st_ff.val == $past(st_ff.val))
    else $error("value register changed without a write");

  // a finished write, then a read of the same register, sees the new data
  a_en_rd_after_wr: assert property (s_wr_done(IDX_PIN_OUTPUT_ENABLE) ##1 s_rd_addr(IDX_PIN_OUTPUT_ENABLE)
    |=> hrdata_o[7:0] == $past(hwdata_i[7:0], 2))
    else $error("enable read after write returned old data");

  a_val_rd_after_wr: assert property (s_wr_done(IDX_PIN_OUTPUT_VALUE) ##1 s_rd_addr(IDX_PIN_OUTPUT_VALUE)
    |=> hrdata_o[7:0] == $past(hwdata_i[7:0], 2))
    else $error("value read after write returned old data");

  // a write to the level register does not disturb the next level read
  a_level_rd_after_wr: assert property (s_wr_done(IDX_PIN_INPUT_LEVEL) ##1 s_rd_addr(IDX_PIN_INPUT_LEVEL)
    |=> hrdata_o == {24'h00_0000, $past(pif.level)})
    else $error("level read after write not the pin levels");

  // address phase of a read from an index that holds no register
  sequence s_hole_rd;
    addr_take && !hwrite_i && req_idx != IDX_PIN_OUTPUT_ENABLE
      && req_idx != IDX_PIN_OUTPUT_VALUE && req_idx != IDX_PIN_INPUT_LEVEL;
  endsequence

  // a whole write to an index that holds no register
  sequence s_hole_wr;
    addr_take && hwrite_i && req_idx != IDX_PIN_OUTPUT_ENABLE
      && req_idx != IDX_PIN_OUTPUT_VALUE && req_idx != IDX_PIN_INPUT_LEVEL ##1 hready_i;
  endsequence

  // holes read as zero
  a_hole_read: assert property (s_hole_rd |=> hrdata_o == 32'h0000_0000)
    else $error("unmapped index read back nonzero");

  // holes swallow writes
  a_hole_no_write: assert property (s_hole_wr
    |=> st_ff.en == $past(st_ff.en) && st_ff.val == $past(st_ff.val))
    else $error("unmapped write changed state");

  // read data stands only in a read data phase and is zero otherwise
  a_rdata_idle: assert property (!$past(addr_take && !hwrite_i) |-> hrdata_o == 32'h0000_0000)
    else $error("read data outside a read data phase");

  // only the low byte of read data ever carries a register
  a_rdata_upper: assert property (hrdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  // a taken write enters its data phase, a taken read its own
  a_wr_phase: assert property (addr_take && hwrite_i |=> st_ff.phase == GPM_WR)
    else $error("write data phase not entered");

  a_rd_phase: assert property (addr_take && !hwrite_i |=> st_ff.phase == GPM_RD)
    else $error("read data phase not entered");

  // bus phase state stays one-hot
  a_phase_onehot: assert property ($onehot(st_ff.phase))
    else $error("bus phase state not one-hot");

  // clock pin level reaches bit 6 of the level register after two stages
  a_clk_level_sync: assert property (st_ff.warm && $past(st_ff.warm)
    |-> pif.level[CLK_BIT] == $past(pad_in_i[CLK_BIT], 2))
    else $error("clock pin level not two stages behind pin");
endmodule

/* tb/gpm_pin_partner.sv */
// model of the outside circuitry wired to the eight repurposed pins
`timescale 1ns/1ps
module gpm_pin_partner
(
  input wire logic [7:0] pad_out_i, // port output buffers
  input wire logic [7:0] pad_oe_i, // port drive enables, high drives
  input wire logic [7:0] ext_drv_i, // level the outside source applies
  output logic [7:0] pad_in_o // resolved pin levels
);
  // outside source yields wherever the port drives, so no contention is modelled
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_drv_i);
endmodule

/* tb/tb_multiplexed_pin_gpio_port.sv */
// self-checking bench for the multiplexed-pin gpio port
`timescale 1ns/1ps
module tb_multiplexed_pin_gpio_port
  import gpm_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus, outputs and bookkeeping
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic scan_active_i = 1'b0;
  logic [7:0] dflt_out_i = 8'h00;
  logic [7:0] dflt_oe_i = 8'h00;
  logic [7:0] ext_drv = 8'h00;
  logic [7:0] pad_in_i;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic [7:0] pad_out_o;
  logic [7:0] pad_oe_o;
  logic dphase = 1'b0;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int samples_checked = 0;
  int seed = 3;

  gpm_gpio_port i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .scan_active_i(scan_active_i), .dflt_out_i(dflt_out_i), .dflt_oe_i(dflt_oe_i),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o));

  gpm_pin_partner i_partner (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_drv_i(ext_drv),
    .pad_in_o(pad_in_i));

  // 25 mhz clock
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // compare, verdict and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // waits for hready high at a rising edge, bounded
  task automatic hwait;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_total++;
        test_done;
      end
      @(posedge clk_i);
    end
  endtask

  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    haddr_i <= {22'h0, idx, 2'b00};
    hwrite_i <= w;
    htrans_i <= HTRANS_NONSEQ;
    hsel_i <= 1'b1;
    hwait;
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    hwait;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask

  // checks pin drive two edges after the task is entered, returns expected pin levels
  task automatic pins(input logic [7:0] en, input logic [7:0] val, output logic [7:0] lvl);
    logic [7:0] own;
    logic [7:0] oe;
    logic [7:0] out;
    own = en & ~(scan_active_i ? SCAN_PIN_MASK : 8'h00);
    oe = own | (~own & dflt_oe_i);
    out = (own & val) | (~own & dflt_out_i);
    lvl = (oe & out) | (~oe & ext_drv);
    repeat (2) @(posedge clk_i);
    #1;
    check(32'(pad_oe_o), 32'(oe));
    check(32'(pad_out_o), 32'(out));
    repeat (3) @(posedge clk_i);
  endtask

  // read data phase watcher: pops the oldest note per read
  always @(posedge clk_i)
  begin
    if (dphase)
    begin
      check(hrdata_o, exp_q.pop_front());
      check(32'(hresp_o), 32'(HRESP_OKAY));
    end
    dphase <= hsel_i & htrans_i[1] & hreadyout_o & ~hwrite_i;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] en;
    logic [7:0] v;
    logic [7:0] lvl;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(IDX_PIN_OUTPUT_ENABLE, 32'(RST_PIN_OUTPUT_ENABLE));
    rd(IDX_PIN_OUTPUT_VALUE, 32'(RST_PIN_OUTPUT_VALUE));
    pins(8'h00, 8'h00, lvl);
    rd(IDX_PIN_INPUT_LEVEL, 32'(lvl));
    // walk each enable bit, then a random mix, without and with scan active
    for (int s = 0; s < 2; s++)
    begin
      for (int i = 0; i < 9; i++)
      begin
        en = (i == 8) ? 8'($random(seed)) : 8'h01 << i;
        v = 8'($random(seed));
        scan_active_i <= s[0];
        dflt_out_i <= 8'($random(seed));
        dflt_oe_i <= 8'($random(seed));
        ext_drv <= 8'($random(seed));
        bus(1'b1, IDX_PIN_OUTPUT_ENABLE, {24'($random(seed)), en});
        bus(1'b1, IDX_PIN_OUTPUT_VALUE, {24'($random(seed)), v});
        rd(IDX_PIN_OUTPUT_ENABLE, 32'(en));
        rd(IDX_PIN_OUTPUT_VALUE, 32'(v));
        pins(en, v, lvl);
        rd(IDX_PIN_INPUT_LEVEL, 32'(lvl));
        bus(1'b1, IDX_PIN_INPUT_LEVEL, 32'(~lvl));
        rd(IDX_PIN_INPUT_LEVEL, 32'(lvl));
      end
    end
    // unmapped neighbours read zero and swallow writes
    bus(1'b1, 8'h47, 32'($random(seed)));
    rd(8'h47, 32'h0);
    rd(8'h43, 32'h0);
    rd(IDX_PIN_OUTPUT_ENABLE, 32'(en));
    rd(IDX_PIN_OUTPUT_VALUE, 32'(v));
    // a read right after a write returns the new data
    bus(1'b1, IDX_PIN_OUTPUT_VALUE, {24'h00_0000, ~v});
    rd(IDX_PIN_OUTPUT_VALUE, {24'h00_0000, ~v});
    bus(1'b1, IDX_PIN_OUTPUT_ENABLE, {24'h00_0000, ~en});
    rd(IDX_PIN_OUTPUT_ENABLE, {24'h00_0000, ~en});
    repeat (4) @(posedge clk_i);
    check(32'(exp_q.size()), 32'h0);
    test_done;
  end
endmodule
